// File: can_mailbox_store.sv
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
`include "can_mailbox_store_consts.svh"

// Operation
// - sixteen objects, each with 29-bit identifier, eight data bytes, control bits
// - object n sits at index 0200H plus n times 10H, sixteen words each
// - objects 0..14 transmit or receive; object 15 receive only
// - identifier at 00H/02H, control 04H, data pairs 06H..0CH, stamp 0EH
// - software sets send request; engine sends alone, request clears when done
// - each object can interrupt after a good send or receive
// - lower identifier value wins priority among pending transmit objects
// - matching remote frame rewrites identifier and answers when hold and filter set
// - standard identifiers leave low eighteen bits indeterminate
// - clearing enable during reception stops that reception
// - control bit 4 selects data frame or remote frame
// - control bits 3..0 hold the length code, 0 to 8 bytes
// - a received frame stores its frame type and length code
// - storage shared by the protocol engine and the processor bus
// - processor writes to receive object data are ignored
module can_mailbox_store
  import can_mailbox_store_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // interrupt
  output logic irq,
  // engine receive side
  input wire logic rx_busy,
  input wire logic [3:0] rx_busy_obj,
  output logic rx_abort,
  input wire logic rx_store,
  input wire logic [3:0] rx_obj,
  input wire logic [28:0] rx_id,
  input wire logic rx_remote,
  input wire logic [3:0] rx_dlc,
  input wire logic [63:0] rx_data,
  input wire logic [15:0] rx_stamp,
  // engine remote frame match
  input wire logic remote_match,
  input wire logic [3:0] remote_obj,
  input wire logic [28:0] remote_id,
  // engine transmit side
  input wire logic tx_done,
  input wire logic [3:0] tx_done_obj,
  output logic tx_valid,
  output logic [3:0] tx_obj,
  output logic [28:0] tx_id,
  output logic [4:0] tx_ctl,
  output logic [63:0] tx_data
);

  store_state_t s;
  store_state_t q;
  logic acc;
  logic [3:0] wobj;
  logic [3:0] woff;
  logic [15:0] wd;
  logic [15:0] sw_set_vec;
  logic [15:0] cand;
  logic best_ok;
  logic [28:0] best_id;
  logic [3:0] best_n;
  logic rx_ok;
  logic remote_ok;
  logic [63:0] rx_obj_data;
  logic [63:0] wr_obj_data;
  logic [15:0] wr_obj_stamp;
  logic [15:0] send_mask;
  logic [28:0] remote_obj_ident;
  logic [15:0] pend_vec;
  logic [15:0] beats_winner;

  // ----------------------------------------
  // register read mux
  // ----------------------------------------
  function automatic logic [31:0] rd_word(input store_state_t st, input logic [11:0] idx);
    logic [31:0] r;
    logic [3:0] n;
    r = `RST_WORD;
    n = idx[7:4];
    if (idx[11:8] == `AREA_OBJECTS) begin
      unique case (idx[3:0])
        `OFF_ID_HIGH: r = {19'h0_0000, st.ident[n][28:16]};
        `OFF_ID_LOW: r = {16'h0000, st.ident[n][15:0]};
        `OFF_CTL_LOW: r = {27'h000_0000, st.ctl[n]};
        `OFF_DATA_0_1: r = {16'h0000, st.data[n][15:0]};
        `OFF_DATA_2_3: r = {16'h0000, st.data[n][31:16]};
        `OFF_DATA_4_5: r = {16'h0000, st.data[n][47:32]};
        `OFF_DATA_6_7: r = {16'h0000, st.data[n][63:48]};
        `OFF_STAMP: r = {16'h0000, st.stamp[n]};
        default: r = `RST_WORD;
      endcase
    end else if (idx[11:8] == `AREA_CONTROL) begin
      unique case (idx[7:0])
        `OFF_OBJ_ENABLE: r = {16'h0000, st.enable};
        `OFF_DIRECTION: r = {16'h0000, st.is_tx};
        `OFF_SEND_SET: r = {16'h0000, st.send_req};
        `OFF_INT_STATUS: r = {16'h0000, st.int_stat};
        `OFF_INT_ENABLE: r = {16'h0000, st.int_en};
        `OFF_REMOTE_HOLD: r = {16'h0000, st.remote_hold};
        `OFF_GLOBAL_FILTER: r = {31'h0000_0000, st.glob_filter};
        default: r = `RST_WORD;
      endcase
    end
    return r;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    q = s;
    q.rx_abort = 1'b0;
    q.hready = 1'b1;
    q.hresp = 1'b0;
    wobj = s.wr_idx[7:4];
    woff = s.wr_idx[3:0];
    wd = hwdata[15:0];
    sw_set_vec = `RST_VEC16;
    // data phase of a bus write, shared with the engine below
    if (s.wr_pend && s.wr_idx[11:8] == `AREA_OBJECTS) begin
      unique case (woff)
        `OFF_ID_HIGH: q.ident[wobj][28:16] = wd[`ID_HIGH_MSB:0];
        `OFF_ID_LOW: q.ident[wobj][15:0] = wd;
        `OFF_CTL_LOW: q.ctl[wobj] = wd[4:0];
        `OFF_DATA_0_1: if (s.is_tx[wobj]) q.data[wobj][15:0] = wd;
        `OFF_DATA_2_3: if (s.is_tx[wobj]) q.data[wobj][31:16] = wd;
        `OFF_DATA_4_5: if (s.is_tx[wobj]) q.data[wobj][47:32] = wd;
        `OFF_DATA_6_7: if (s.is_tx[wobj]) q.data[wobj][63:48] = wd;
        default: q.ctl[wobj] = s.ctl[wobj];
      endcase
    end
    if (s.wr_pend && s.wr_idx[11:8] == `AREA_CONTROL) begin
      unique case (s.wr_idx[7:0])
        `OFF_OBJ_ENABLE: q.enable = wd;
        `OFF_DIRECTION: q.is_tx = wd;
        `OFF_SEND_SET: sw_set_vec = wd & s.is_tx;
        `OFF_INT_CLEAR: q.int_stat = s.int_stat & ~wd;
        `OFF_INT_ENABLE: q.int_en = wd;
        `OFF_REMOTE_HOLD: q.remote_hold = wd;
        `OFF_GLOBAL_FILTER: q.glob_filter = wd[0];
        default: q.int_en = s.int_en;
      endcase
    end
    q.is_tx[`RECEIVE_ONLY_OBJ] = 1'b0;
    // enable dropped under a running reception
    if (rx_busy && s.enable[rx_busy_obj] && !q.enable[rx_busy_obj]) begin
      q.rx_abort = 1'b1;
    end
    // an event in the cycle of a clear wins over the clear
    // transmission finished: request drops, event latches
    if (tx_done) begin
      q.send_req[tx_done_obj] = 1'b0;
      q.int_stat[tx_done_obj] = 1'b1;
    end
    q.send_req = q.send_req | sw_set_vec;
    // placed after the bus write so a frame beats a write in the same cycle
    // reception lands only in an enabled receive object
    rx_ok = rx_store && q.enable[rx_obj] && !s.is_tx[rx_obj];
    if (rx_ok) begin
      q.ident[rx_obj] = rx_id;
      q.ctl[rx_obj] = {rx_remote, rx_dlc};
      q.data[rx_obj] = rx_data;
      q.stamp[rx_obj] = rx_stamp;
      q.int_stat[rx_obj] = 1'b1;
    end
    // remote request answered with the requester's identifier
    remote_ok = remote_match && s.is_tx[remote_obj] && q.enable[remote_obj] &&
                s.remote_hold[remote_obj] && s.glob_filter;
    if (remote_ok) begin
      q.ident[remote_obj] = remote_id;
      q.send_req[remote_obj] = 1'b1;
    end
    // bus address phase
    acc = hsel && htrans[1] && hready;
    q.wr_pend = acc && hwrite;
    if (acc) begin
      q.wr_idx = haddr[13:2];
    end
    if (acc && !hwrite) begin
      q.hrdata = rd_word(q, haddr[13:2]);
    end
    // lowest identifier among pending transmit objects
    cand = q.send_req & q.enable & q.is_tx;
    best_ok = 1'b0;
    best_id = 29'h1fff_ffff;
    best_n = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (cand[i] && (!best_ok || q.ident[i] < best_id)) begin
        best_ok = 1'b1;
        best_id = q.ident[i];
        best_n = 4'(i);
      end
    end
    q.tx_valid = best_ok;
    q.tx_obj = best_n;
    q.tx_id = q.ident[best_n];
    q.tx_ctl = q.ctl[best_n];
    q.tx_data = q.data[best_n];
    q.irq = |(q.int_stat & q.int_en);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.hready <= 1'b1;
    end else begin
      s <= q;
    end
  end

  assign hreadyout = s.hready;
  assign hresp = s.hresp;
  assign hrdata = s.hrdata;
  assign irq = s.irq;
  assign rx_abort = s.rx_abort;
  assign tx_valid = s.tx_valid;
  assign tx_obj = s.tx_obj;
  assign tx_id = s.tx_id;
  assign tx_ctl = s.tx_ctl;
  assign tx_data = s.tx_data;
  assign rx_obj_data = s.data[rx_obj];
  assign wr_obj_data = s.data[wobj];
  assign wr_obj_stamp = s.stamp[wobj];
  assign send_mask = wd & s.is_tx;
  assign remote_obj_ident = s.ident[remote_obj];

  // ----------------------------------------
  // priority reference for the checks
  // ----------------------------------------
  for (genvar g = 0; g < 16; g++) begin : prio_ref
    assign pend_vec[g] = s.send_req[g] && s.enable[g] && s.is_tx[g];
    assign beats_winner[g] = pend_vec[g] && (s.ident[g] < tx_id);
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence rx_taken;
    rx_store && s.enable[rx_obj] && !s.is_tx[rx_obj] && !(s.wr_pend && s.wr_idx[11:8] == `AREA_CONTROL);
  endsequence

  sequence rx_data_write;
    s.wr_pend && s.wr_idx[11:8] == `AREA_OBJECTS && !s.is_tx[wobj] && !rx_store &&
    (woff == `OFF_DATA_0_1 || woff == `OFF_DATA_6_7);
  endsequence

  sequence ctl_read;
    hsel && htrans[1] && hready && !hwrite && haddr[13:10] == `AREA_OBJECTS &&
    haddr[5:2] inside {`OFF_CTL_LOW, `OFF_CTL_HIGH};
  endsequence

  sequence remote_hit;
    remote_match && s.is_tx[remote_obj] && s.enable[remote_obj] && s.remote_hold[remote_obj] &&
    s.glob_filter && !s.wr_pend;
  endsequence

  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("slave stalled or answered an error");
  rx_only_a: assert property (!s.is_tx[`RECEIVE_ONLY_OBJ])
    else $error("object 15 became a transmit object");
  rx_event_a: assert property (rx_taken |=> s.int_stat[$past(rx_obj)] && (irq || !s.int_en[$past(rx_obj)]))
    else $error("receive event not latched or not signalled");
  rx_ctl_a: assert property (rx_taken |=> s.ctl[$past(rx_obj)] == $past({rx_remote, rx_dlc}))
    else $error("received frame type or length not stored");
  rx_abort_a: assert property (rx_abort |-> $past(rx_busy) && !s.enable[$past(rx_busy_obj)])
    else $error("reception stopped without enable being cleared");
  rx_ignore_a: assert property (rx_store && !s.enable[rx_obj] && !s.wr_pend |=>
                                s.data[$past(rx_obj)] == $past(rx_obj_data))
    else $error("disabled object took a received frame");
  tx_clear_a: assert property (tx_done && !s.wr_pend && !remote_match |=> !s.send_req[$past(tx_done_obj)])
    else $error("send request still pending after completion");
  remote_a: assert property (remote_hit |=> s.ident[$past(remote_obj)] == $past(remote_id) &&
                             s.send_req[$past(remote_obj)] ##1 tx_valid)
    else $error("remote frame not answered with its identifier");
  rx_wr_drop_a: assert property (rx_data_write |=> s.data[$past(wobj)] == $past(wr_obj_data))
    else $error("write reached a receive object data word");
  ctl_zero_a: assert property (ctl_read |=> hrdata[31:5] == 27'h000_0000)
    else $error("unused control bits read nonzero");
  prio_pick_a: assert property (tx_valid |-> beats_winner == `RST_VEC16 && pend_vec[tx_obj] &&
                                tx_id == s.ident[tx_obj])
    else $error("chosen transmit object inconsistent");

  // ----------------------------------------
  // register bus checks
  // ----------------------------------------
  sequence unmapped_read;
    hsel && htrans[1] && hready && !hwrite && haddr[13:10] != `AREA_OBJECTS && haddr[13:10] != `AREA_CONTROL;
  endsequence

  sequence en_write;
    s.wr_pend && s.wr_idx == {`AREA_CONTROL, `OFF_OBJ_ENABLE};
  endsequence

  sequence ien_write;
    s.wr_pend && s.wr_idx == {`AREA_CONTROL, `OFF_INT_ENABLE};
  endsequence

  sequence hold_write;
    s.wr_pend && s.wr_idx == {`AREA_CONTROL, `OFF_REMOTE_HOLD};
  endsequence

  sequence send_taken;
    s.wr_pend && s.wr_idx == {`AREA_CONTROL, `OFF_SEND_SET} && !tx_done;
  endsequence

  sequence id_low_write;
    s.wr_pend && s.wr_idx[11:8] == `AREA_OBJECTS && woff == `OFF_ID_LOW && !rx_store && !remote_match;
  endsequence

  sequence stamp_write;
    s.wr_pend && s.wr_idx[11:8] == `AREA_OBJECTS && woff == `OFF_STAMP && !rx_store;
  endsequence

  unmapped_rd_a: assert property (unmapped_read |=> hrdata == `RST_WORD)
    else $error("unmapped read returned nonzero data");
  rd_hold_a: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");
  en_write_a: assert property (en_write |=> s.enable == $past(wd))
    else $error("object enable write not taken");
  ien_write_a: assert property (ien_write |=> s.int_en == $past(wd))
    else $error("interrupt enable write not taken");
  hold_write_a: assert property (hold_write |=> s.remote_hold == $past(wd))
    else $error("remote hold write not taken");
  send_set_a: assert property (send_taken |=> (s.send_req & $past(send_mask)) == $past(send_mask))
    else $error("send request write did not set the request");
  id_write_a: assert property (id_low_write |=> s.ident[$past(wobj)][15:0] == $past(wd))
    else $error("identifier low word write not taken");
  stamp_ro_a: assert property (stamp_write |=> s.stamp[$past(wobj)] == $past(wr_obj_stamp))
    else $error("bus write changed a capture stamp");

  // ----------------------------------------
  // engine side checks
  // ----------------------------------------
  sequence clear_taken;
    s.wr_pend && s.wr_idx == {`AREA_CONTROL, `OFF_INT_CLEAR} && !tx_done && !rx_store;
  endsequence

  sequence remote_refused;
    remote_match && !s.glob_filter && !s.wr_pend && !rx_store;
  endsequence

  irq_level_a: assert property (irq == |(s.int_stat & s.int_en))
    else $error("interrupt level does not follow enabled status");
  stat_clear_a: assert property (clear_taken |=> (s.int_stat & $past(wd)) == `RST_VEC16)
    else $error("status bit survived its clear");
  tx_event_a: assert property (tx_done |=> s.int_stat[$past(tx_done_obj)])
    else $error("transmit completion not latched");
  rx_store_a: assert property (rx_taken |=> s.ident[$past(rx_obj)] == $past(rx_id) &&
                               s.data[$past(rx_obj)] == $past(rx_data) &&
                               s.stamp[$past(rx_obj)] == $past(rx_stamp))
    else $error("received frame not stored");
  remote_refuse_a: assert property (remote_refused |=>
                                    s.ident[$past(remote_obj)] == $past(remote_obj_ident))
    else $error("refused remote frame rewrote an identifier");
  tx_idle_a: assert property (!tx_valid |-> pend_vec == `RST_VEC16)
    else $error("pending transmit object not offered");

endmodule

// File: can_mailbox_store_consts.svh
`ifndef CAN_MAILBOX_STORE_CONSTS_SVH
`define CAN_MAILBOX_STORE_CONSTS_SVH

// word index = haddr[13:2]; index[11:8] picks the area
`define AREA_OBJECTS 4'h2
`define AREA_CONTROL 4'h3

// offsets inside one object, in word index units
`define OFF_ID_HIGH 4'h0
`define OFF_ID_LOW 4'h2
`define OFF_CTL_LOW 4'h4
`define OFF_CTL_HIGH 4'h5
`define OFF_DATA_0_1 4'h6
`define OFF_DATA_2_3 4'h8
`define OFF_DATA_4_5 4'ha
`define OFF_DATA_6_7 4'hc
`define OFF_STAMP 4'he

// offsets inside the control area, in word index units
`define OFF_OBJ_ENABLE 8'h00
`define OFF_DIRECTION 8'h02
`define OFF_SEND_SET 8'h04
`define OFF_INT_STATUS 8'h06
`define OFF_INT_CLEAR 8'h08
`define OFF_INT_ENABLE 8'h0a
`define OFF_REMOTE_HOLD 8'h0c
`define OFF_GLOBAL_FILTER 8'h0e

// field positions
`define CTL_REMOTE_BIT 4
`define ID_HIGH_MSB 12
`define RECEIVE_ONLY_OBJ 4'hf

// reset values
`define RST_VEC16 16'h0000
`define RST_WORD 32'h0000_0000

`endif

// File: can_mailbox_store_pkg.sv
package can_mailbox_store_pkg;

  typedef struct packed {
    logic [15:0][28:0] ident;
    logic [15:0][4:0] ctl;
    logic [15:0][63:0] data;
    logic [15:0][15:0] stamp;
    logic [15:0] enable;
    logic [15:0] is_tx;
    logic [15:0] send_req;
    logic [15:0] remote_hold;
    logic glob_filter;
    logic [15:0] int_stat;
    logic [15:0] int_en;
    logic wr_pend;
    logic [11:0] wr_idx;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    logic irq;
    logic rx_abort;
    logic tx_valid;
    logic [3:0] tx_obj;
    logic [28:0] tx_id;
    logic [4:0] tx_ctl;
    logic [63:0] tx_data;
  } store_state_t;

endpackage

// File: engine_model.sv
`timescale 1ns/1ps
module engine_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // answer pace, in cycles
  input wire logic [3:0] delay,
  // transmit handshake with the store
  input wire logic tx_valid,
  input wire logic [3:0] tx_obj,
  output logic tx_done,
  output logic [3:0] tx_done_obj,
  // finished objects, newest in the low nibble
  output logic [7:0] done_log
);
  logic [3:0] cnt;
  // ----------------------------------------
  // sends the current winner after delay cycles
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {cnt, tx_done, tx_done_obj, done_log} <= '0;
    end else if (tx_valid && !tx_done && cnt >= delay) begin
      tx_done <= 1'b1;
      tx_done_obj <= tx_obj;
      done_log <= {done_log[3:0], tx_obj};
      cnt <= 4'h0;
    end else begin
      // object lines toggle while no completion is shown
      tx_done <= 1'b0;
      tx_done_obj <= ~tx_done_obj;
      cnt <= tx_valid ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule

// File: tb.sv
`timescale 1ns/1ps
module tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, rx_abort, tx_valid, tx_done;
  logic rx_busy, rx_store, rx_remote, remote_match;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] rx_busy_obj, rx_obj, rx_dlc, remote_obj, tx_done_obj, tx_obj, delay;
  logic [4:0] tx_ctl;
  logic [7:0] done_log;
  logic [15:0] rx_stamp;
  logic [28:0] rx_id, remote_id, tx_id;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [63:0] rx_data, tx_data;
  int bad_count = 0, tests_run = 0, cycles = 0;
  localparam logic [31:0] a_en = 32'h0000_0c00, a_dir = 32'h0000_0c08, a_send = 32'h0000_0c10;
  localparam logic [31:0] a_stat = 32'h0000_0c18, a_clr = 32'h0000_0c20, a_ien = 32'h0000_0c28;
  localparam logic [31:0] a_hold = 32'h0000_0c30, a_glob = 32'h0000_0c38;

  can_mailbox_store uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .irq, .rx_busy, .rx_busy_obj, .rx_abort, .rx_store, .rx_obj, .rx_id, .rx_remote,
    .rx_dlc, .rx_data, .rx_stamp, .remote_match, .remote_obj, .remote_id, .tx_done, .tx_done_obj, .tx_valid,
    .tx_obj, .tx_id, .tx_ctl, .tx_data);
  engine_model eng (.hclk, .hresetn, .delay, .tx_valid, .tx_obj, .tx_done, .tx_done_obj, .done_log);

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    {hsel, haddr, hwrite, htrans} <= {1'b1, a, w, 2'b10};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rchk(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task wait_idle;
    for (int n = 0; n < 60; n++) begin
      bus(1'b0, a_send, 32'h0);
      if (rd === 32'h0) break;
    end
  endtask
  function automatic logic [31:0] ob(input logic [3:0] n, input logic [7:0] off);
    return 32'h0000_0800 + {22'h0, n, 6'h00} + {24'h0, off};
  endfunction
  task rx_frame(input logic [3:0] o, input logic [28:0] id, input logic [3:0] dlc);
    @(posedge hclk);
    {rx_store, rx_obj, rx_id, rx_remote, rx_dlc} <= {1'b1, o, id, 1'b1, dlc};
    {rx_data, rx_stamp} <= {64'h8877_6655_4433_2211, 16'hbeef};
    @(posedge hclk);
    {rx_store, rx_id, rx_data} <= {1'b0, ~id, ~rx_data};
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    wr(ob(4'h2, 8'h00), 32'hffff_1abc);
    wr(ob(4'h2, 8'h08), 32'hffff_5678);
    wr(ob(4'h2, 8'h10), 32'h0000_00f8);
    wr(ob(4'h2, 8'h14), 32'h0000_ffff);
    wr(ob(4'hf, 8'h38), 32'h0000_1234);
    rchk(ob(4'h2, 8'h00), 32'h0000_1abc);
    rchk(ob(4'h2, 8'h08), 32'h0000_5678);
    rchk(ob(4'h2, 8'h10), 32'h0000_0018);
    rchk(ob(4'h2, 8'h14), 32'h0);
    rchk(ob(4'hf, 8'h38), 32'h0);
    rchk(32'h0000_1000, 32'h0);
    chk(hresp, 1'b0);
    wr(ob(4'h2, 8'h18), 32'h0000_a55a);
    rchk(ob(4'h2, 8'h18), 32'h0);
    wr(a_dir, 32'h0000_ffff);
    rchk(a_dir, 32'h0000_7fff);
    wr(ob(4'h2, 8'h18), 32'h0000_a55a);
    rchk(ob(4'h2, 8'h18), 32'h0000_a55a);
    wr(ob(4'hf, 8'h18), 32'h0000_a55a);
    rchk(ob(4'hf, 8'h18), 32'h0);
    $display("t_regs done");
  endtask
  task t_rx;
    wr(a_dir, 32'h0000_0012);
    wr(a_en, 32'h0000_003a);
    wr(a_ien, 32'h0000_0008);
    rx_frame(4'h3, 29'h1234_5678, 4'h8);
    rx_frame(4'h6, 29'h0000_0777, 4'h2);
    rchk(ob(4'h3, 8'h00), 32'h0000_1234);
    rchk(ob(4'h3, 8'h08), 32'h0000_5678);
    rchk(ob(4'h3, 8'h10), 32'h0000_0018);
    rchk(ob(4'h3, 8'h18), 32'h0000_2211);
    rchk(ob(4'h3, 8'h30), 32'h0000_8877);
    rchk(ob(4'h3, 8'h38), 32'h0000_beef);
    rchk(ob(4'h6, 8'h08), 32'h0);
    rchk(a_stat, 32'h0000_0008);
    chk(irq, 1'b1);
    wr(a_ien, 32'h0);
    repeat (2) @(posedge hclk);
    chk(irq, 1'b0);
    wr(a_ien, 32'h0000_0008);
    wr(a_clr, 32'h0000_0008);
    repeat (2) @(posedge hclk);
    chk(irq, 1'b0);
    rchk(a_stat, 32'h0);
    $display("t_rx done");
  endtask
  task t_abort;
    int n;
    n = 0;
    @(posedge hclk);
    {rx_busy, rx_busy_obj} <= {1'b1, 4'h5};
    wr(a_en, 32'h0000_001a);
    repeat (4) begin
      @(posedge hclk);
      if (rx_abort === 1'b1) n++;
    end
    chk(n, 1);
    rx_busy <= 1'b0;
    $display("t_abort done");
  endtask
  task t_tx;
    wr(a_en, 32'h0000_0008);
    wr(ob(4'h1, 8'h08), 32'h0000_0100);
    wr(ob(4'h4, 8'h08), 32'h0000_0050);
    wr(ob(4'h4, 8'h10), 32'h0000_0003);
    wr(ob(4'h4, 8'h18), 32'h0000_bbaa);
    wr(a_en, 32'h0000_001a);
    wr(a_ien, 32'h0000_0012);
    rchk(a_en, 32'h0000_001a);
    rchk(a_ien, 32'h0000_0012);
    wr(a_send, 32'h0000_0012);
    repeat (2) @(posedge hclk);
    chk({tx_valid, tx_obj}, 5'h14);
    chk({tx_id, tx_ctl, tx_data[15:0]}, {29'h0000_0050, 5'h03, 16'hbbaa});
    wait_idle();
    chk(rd, 32'h0);
    chk(done_log, 8'h41);
    rchk(a_stat, 32'h0000_0012);
    wr(a_clr, 32'h0000_0012);
    rchk(a_clr, 32'h0);
    wr(a_send, 32'h0000_0008);
    rchk(a_send, 32'h0);
    $display("t_tx done");
  endtask
  task t_remote;
    delay <= 4'hf;
    wr(a_hold, 32'h0000_0002);
    wr(a_glob, 32'h0000_0001);
    rchk(a_hold, 32'h0000_0002);
    rchk(a_glob, 32'h0000_0001);
    for (int k = 0; k < 2; k++) begin
      @(posedge hclk);
      {remote_match, remote_obj, remote_id} <= {1'b1, 4'h1, k ? 29'h0555_0042 : 29'h0abc_0123};
      @(posedge hclk);
      {remote_match, remote_id} <= {1'b0, ~remote_id};
      wait_idle();
      chk(done_log, k ? 8'h11 : 8'h11);
      rchk(ob(4'h1, 8'h00), 32'h0000_0abc);
      rchk(ob(4'h1, 8'h08), 32'h0000_0123);
      wr(a_glob, 32'h0);
    end
    $display("t_remote done");
  endtask
  initial begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata, rx_busy, rx_busy_obj, rx_store, rx_obj} = '0;
    {rx_id, rx_remote, rx_dlc, rx_data, rx_stamp, remote_match, remote_obj, remote_id} = '0;
    hsize = 3'h2;
    delay = 4'h6;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_rx();
    t_abort();
    t_tx();
    t_remote();
    report_and_stop();
  end
endmodule
